// ==== verif/cfs_ctrl_model.sv ====
// Purpose: Behavioural CAN controller driving the transmit data and mode pins.
// Assumes: The bench hands over its requests on core_clk; the model registers them.
// Notes:   The go-to-sleep code is held GS_HOLD cycles unless hurry asks for a short hold.
`timescale 1ns/100ps
`default_nettype none
module cfs_ctrl_model #(
    parameter int GS_HOLD = 5100
) (
    // Clock, reset and bench requests.
    input  wire logic       core_clk,
    input  wire logic       resetn,
    input  wire logic [1:0] mode_req,
    input  wire logic       txd_req,
    input  wire logic       hurry,
    // Pins towards the supervisor.
    output logic            txd,
    output logic            standby_sel_n,
    output logic            mode_en
);
    logic [15:0] held;
    // Without hurry the sleep code stays past the longest acceptance time, so a real sleep request is not lost.
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            {standby_sel_n, mode_en, txd} <= 3'b001;
            held <= 16'h0;
        end else begin
            txd <= txd_req;
            held <= ({standby_sel_n, mode_en} == 2'b01) ? held + 16'h1 : 16'h0;
            if ({standby_sel_n, mode_en} != 2'b01 || hurry || held >= 16'(GS_HOLD)) begin
                {standby_sel_n, mode_en} <= mode_req;
            end
        end
    end
endmodule // cfs_ctrl_model
`default_nettype wire

// ==== verif/cfs_supervisor_test.sv ====
// Purpose: Self-checking bench of the CAN fault and wake supervisor.
// Assumes: Failure 4, 6, 7, low-power and transmit counts shortened; failure 3, fast recovery, wake and sleep counts at full size.
// Notes:   Outputs are registered, so they are sampled at clock edges.
`timescale 1ns/100ps
`default_nettype none
module cfs_supervisor_test;
    import cfs_pkg::*;
    localparam int F6D = 50, F6R = 100, F47 = 3500, LPD = 80, LPR = 80, TMO = 60;
    logic core_clk, resetn, txd_req, hurry, m_txd, m_sel_n, m_en, pready, pslverr;
    logic fault_flag_n, regulator_switch_out, bus_drive_dom;
    logic [1:0] mode_req;
    logic [7:0] pin_lo;
    logic [31:0] prdata;
    cfs_apb_req_t apb_req;
    cfs_pins_t pins_in;
    int n_errors, checks;
    assign pins_in = {m_txd, m_sel_n, m_en, pin_lo};
    cfs_supervisor #(.F6_DET(CW'(F6D)), .F6_REC(CW'(F6R)), .F47_DET(CW'(F47)), .LP_DET(CW'(LPD)),
        .LP_REC(CW'(LPR)), .TXD_TMO(CW'(TMO))) u_cfs_supervisor (.core_clk, .resetn, .apb_req, .prdata,
        .pready, .pslverr, .pins_in, .fault_flag_n, .regulator_switch_out, .bus_drive_dom);
    cfs_ctrl_model u_cfs_ctrl_model (.core_clk, .resetn, .mode_req, .txd_req, .hurry, .txd(m_txd),
        .standby_sel_n(m_sel_n), .mode_en(m_en));
    // Free-running 100 MHz core clock.
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    // A hung run is cut short well after the expected span of about 0.3 ms.
    initial begin
        #600_000;
        n_errors++;
        results();
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value at %0t: %h, expected %h", $time, got, exp);
        end
    endtask
    task automatic results();
        $display("checks %0d, errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // One APB transfer; an idle edge first keeps two drives of the bus out of one time step.
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] d,
                       output logic e);
        @(posedge core_clk);
        apb_req <= '{1'b1, 1'b0, w, a, wd};
        @(posedge core_clk);
        apb_req.penable <= 1'b1;
        @(posedge core_clk);
        while (pready !== 1'b1) @(posedge core_clk);
        d = prdata;
        e = pslverr;
        apb_req <= '0;
    endtask
    task automatic wait_rd(input int n, output logic [31:0] d);
        logic e;
        repeat (n) @(posedge core_clk);
        apb(1'b0, ADDR_STATUS, 32'h0, d, e);
    endtask
    task automatic set_mode(input logic [1:0] m);
        mode_req <= m;
        repeat (10) @(posedge core_clk);
    endtask
    task automatic t_reg();
        logic [31:0] d;
        logic e;
        chk({28'h0, pready, fault_flag_n, regulator_switch_out, bus_drive_dom}, 32'hE);
        wait_rd(0, d);
        chk(32'(d[12:9]), 32'(MODE_LOWP));
        apb(1'b0, ADDR_CTRL, 32'h0, d, e);
        chk(d, CTRL_RST);
        apb(1'b1, ADDR_CTRL, 32'h0, d, e);
        apb(1'b0, ADDR_CTRL, 32'h0, d, e);
        chk(d, 32'h0);
        apb(1'b1, ADDR_CTRL, 32'hFFFF_FFFF, d, e);
        apb(1'b0, ADDR_CTRL, 32'h0, d, e);
        chk(d, CTRL_RST);
        apb(1'b0, 8'h08, 32'h0, d, e);
        chk({d[30:0], e}, 32'h1);
    endtask
    task automatic t_edge();
        logic [31:0] d;
        set_mode(2'b11);
        for (int k = 0; k < 6; k++) begin
            if (k < 4) pin_lo[6] <= ~pin_lo[6];
            else pin_lo[5] <= ~pin_lo[5];
            wait_rd(8, d);
            chk({30'h0, d[4], fault_flag_n}, (k >= 2 && k < 5) ? 32'h2 : 32'h1);
        end
    endtask
    task automatic t_mode();
        logic [31:0] d;
        cfs_mode_t exp[4] = '{MODE_LOWP, MODE_GOSLEEP, MODE_VSTBY, MODE_NORMAL};
        hurry <= 1'b1;
        for (int k = 3; k >= 0; k--) begin
            set_mode(2'(k));
            wait_rd(0, d);
            chk(32'(d[12:9]), 32'(exp[k]));
        end
        // A sleep code held far too briefly must leave the regulator on.
        chk({30'h0, regulator_switch_out, d[8]}, 32'h2);
        hurry <= 1'b0;
        pin_lo[5:4] <= 2'b11;
        wait_rd(WAKE_FILT_CNT - 20, d);
        chk(32'(d[6]), 32'h0);
        wait_rd(40, d);
        chk({29'h0, d[7:6], fault_flag_n}, 32'h6);
        pin_lo[5:4] <= 2'b00;
        set_mode(2'b11);
        wait_rd(0, d);
        chk(32'(d[7:6]), 32'h0);
        set_mode(2'b01);
        mode_req <= 2'b00;
        wait_rd(5200, d);
        chk({30'h0, regulator_switch_out, d[8]}, 32'h1);
        pin_lo[7] <= 1'b0;
        wait_rd(WAKE_FILT_CNT - 20, d);
        chk(32'(regulator_switch_out), 32'h0);
        wait_rd(40, d);
        chk({30'h0, regulator_switch_out, d[6]}, 32'h3);
        pin_lo[7] <= 1'b1;
    endtask
    task automatic t_fail();
        logic [31:0] d;
        int det, rec;
        for (int m = 0; m < 2; m++) begin
            set_mode(m ? 2'b00 : 2'b11);
            for (int i = 0; i < 4; i++) begin
                if (m && i == 2) continue;
                det = m ? LPD : (i == 0 ? F3_DET_CNT : (i == 2 ? F6D : F47));
                rec = m ? LPR : (i == 2 ? F6R : FAST_REC_CNT);
                pin_lo[i] <= 1'b1;
                wait_rd(det - 10, d);
                chk(32'(d[3:0]), 32'h0);
                wait_rd(25, d);
                chk(32'(d[3:0]), 32'h1 << i);
                if (!m) chk(32'(fault_flag_n), 32'h0);
                pin_lo[i] <= 1'b0;
                wait_rd(rec - 10, d);
                chk(32'(d[3:0]), 32'h1 << i);
                wait_rd(25, d);
                chk(32'(d[3:0]), 32'h0);
            end
        end
    endtask
    task automatic t_txd();
        logic [31:0] d;
        set_mode(2'b11);
        txd_req <= 1'b0;
        wait_rd(30, d);
        chk(32'(bus_drive_dom), 32'h1);
        wait_rd(40, d);
        chk({30'h0, bus_drive_dom, d[5]}, 32'h1);
        txd_req <= 1'b1;
        wait_rd(10, d);
        chk(32'(d[5]), 32'h0);
        txd_req <= 1'b0;
        wait_rd(10, d);
        chk(32'(bus_drive_dom), 32'h1);
        txd_req <= 1'b1;
    endtask
    // Reset for eight cycles, then every scenario in turn.
    initial begin
        {resetn, txd_req, hurry, mode_req} = 5'b01000;
        pin_lo = 8'h80;
        apb_req = '0;
        n_errors = 0;
        checks = 0;
        repeat (8) @(posedge core_clk);
        resetn <= 1'b1;
        t_reg();
        t_edge();
        t_mode();
        t_fail();
        t_txd();
        results();
    end
endmodule // cfs_supervisor_test
`default_nettype wire

// ==== verilog/cfs_persist_timer.sv ====
// Purpose: Persistence timer: a flag follows its condition after a hold time.
// Assumes: Condition is already synchronous to core_clk.
// Notes:   The count that applies depends on the flag's present state.
`timescale 1ns/100ps
`default_nettype none
module cfs_persist_timer
    import cfs_pkg::*;
(
    // Clock and reset.
    input  wire logic          core_clk,
    input  wire logic          resetn,
    // Condition and limits.
    input  wire logic          en,
    input  wire logic          cond,
    input  wire logic [CW-1:0] det_cnt,
    input  wire logic [CW-1:0] rec_cnt,
    // Result.
    output logic               flag
);
    logic [CW-1:0] cnt;
    logic [CW-1:0] next_cnt;
    logic          next_flag;
    logic [CW-1:0] limit;

    default clocking @(posedge core_clk); endclocking
    default disable iff (!resetn);

    // Count while the condition disagrees with the flag; any agreement rearms.
    always_comb begin
        limit     = flag ? rec_cnt : det_cnt;
        next_cnt  = '0;
        next_flag = flag;
        if (!en) begin
            next_flag = 1'b0;
        end else if (cond != flag) begin
            if (cnt >= limit - CW'(1)) begin
                next_flag = cond;
            end else begin
                next_cnt = cnt + CW'(1);
            end
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            cnt  <= '0;
            flag <= 1'b0;
        end else begin
            cnt  <= next_cnt;
            flag <= next_flag;
        end
    end

    flag_rise_a: assert property ($rose(flag) |-> $past(en) && $past(cnt) == $past(det_cnt) - CW'(1))
        else $error("Flag rose before the detection count ran out.");
    flag_fall_a: assert property ($fell(flag) && $past(en) |-> $past(cnt) == $past(rec_cnt) - CW'(1))
        else $error("Flag fell before the recovery count ran out.");

endmodule // cfs_persist_timer
`default_nettype wire

// ==== verilog/cfs_pkg.sv ====
// Purpose: Shared constants and types of the CAN fault and wake supervisor.
// Assumes: The core clock runs at 100 MHz.
// Notes:   Every interval is kept in microseconds; cycle counts are derived here.
`default_nettype none
package cfs_pkg;

    // ************************************************************
    // Time base and interval targets
    // ************************************************************
    localparam int CLK_NS        = 10;
    localparam int CW            = 20;
    localparam int WAKE_FILT_US  = 20;
    localparam int SLEEP_HOLD_US = 20;
    localparam int FAST_REC_US   = 30;
    localparam int F3_DET_US     = 30;
    localparam int F6_DET_US     = 200;
    localparam int F6_REC_US     = 400;
    localparam int F47_DET_US    = 2000;
    localparam int LP_DET_US     = 4000;
    localparam int LP_REC_US     = 4000;
    localparam int TXD_TMO_US    = 2000;

    // Cycle counts; each target sits well inside its window.
    localparam int WAKE_FILT_CNT  = WAKE_FILT_US * 1000 / CLK_NS;
    localparam int SLEEP_HOLD_CNT = SLEEP_HOLD_US * 1000 / CLK_NS;
    localparam int FAST_REC_CNT   = FAST_REC_US * 1000 / CLK_NS;
    localparam int F3_DET_CNT     = F3_DET_US * 1000 / CLK_NS;
    localparam int F6_DET_CNT     = F6_DET_US * 1000 / CLK_NS;
    localparam int F6_REC_CNT     = F6_REC_US * 1000 / CLK_NS;
    localparam int F47_DET_CNT    = F47_DET_US * 1000 / CLK_NS;
    localparam int LP_DET_CNT     = LP_DET_US * 1000 / CLK_NS;
    localparam int LP_REC_CNT     = LP_REC_US * 1000 / CLK_NS;
    localparam int TXD_TMO_CNT    = TXD_TMO_US * 1000 / CLK_NS;

    // Edge-count difference thresholds.
    localparam logic [3:0] EDGE_SET = 4'h3;
    localparam logic [3:0] EDGE_CLR = 4'h1;

    // ************************************************************
    // Register map
    // ************************************************************
    localparam logic [7:0]  ADDR_CTRL   = 8'h00;
    localparam logic [7:0]  ADDR_STATUS = 8'h04;
    localparam logic [31:0] CTRL_RST    = 32'h0000_0007;

    typedef struct packed {
        logic [28:0] rsvd;
        logic        edge_mon_en;
        logic        local_wake_en;
        logic        bus_wake_en;
    } cfs_ctrl_t;

    typedef struct packed {
        logic [18:0] rsvd;
        logic [3:0]  mode;
        logic        sleep;
        logic        pwon;
        logic        wake;
        logic        tx_timeout;
        logic        fail_125;
        logic [3:0]  fail;    // Bits 3..0: failures 7, 6, 4, 3.
    } cfs_status_t;

    typedef struct packed {
        logic       psel;
        logic       penable;
        logic       pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
    } cfs_apb_req_t;

    // Pins from the analog side and the protocol controller.
    typedef struct packed {
        logic       txd;
        logic       standby_sel_n;
        logic       mode_en;
        logic       wake_n;
        logic       canh_dom;
        logic       canl_dom;
        logic       bat_low;
        logic [3:0] fault_cond;  // Bits 3..0: failures 7, 6, 4, 3.
    } cfs_pins_t;

    localparam logic [10:0] PIN_RST = 11'h480;

    typedef enum logic [3:0] {
        MODE_NORMAL  = 4'b0001,
        MODE_VSTBY   = 4'b0010,
        MODE_GOSLEEP = 4'b0100,
        MODE_LOWP    = 4'b1000
    } cfs_mode_t;

endpackage
`default_nettype wire

// ==== verilog/cfs_supervisor.sv ====
// Purpose: Wake filtering, bus failure timing, TXD timeout and mode control.
// Assumes: Analog comparators deliver fault conditions as asynchronous levels.
// Notes:   APB slave with zero wait states; pready is always high.
//
// The address map and register access over APB are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
module cfs_supervisor
    import cfs_pkg::*;
#(
    parameter logic [CW-1:0] F6_DET  = CW'(F6_DET_CNT),
    parameter logic [CW-1:0] F6_REC  = CW'(F6_REC_CNT),
    parameter logic [CW-1:0] F47_DET = CW'(F47_DET_CNT),
    parameter logic [CW-1:0] LP_DET  = CW'(LP_DET_CNT),
    parameter logic [CW-1:0] LP_REC  = CW'(LP_REC_CNT),
    parameter logic [CW-1:0] TXD_TMO = CW'(TXD_TMO_CNT)
) (
    // Clock and reset.
    input  wire logic                  core_clk,
    input  wire logic                  resetn,
    // APB slave.
    input  wire cfs_pkg::cfs_apb_req_t apb_req,
    output logic [31:0]                prdata,
    output logic                       pready,
    output logic                       pslverr,
    // Device pins.
    input  wire cfs_pkg::cfs_pins_t    pins_in,
    output logic                       fault_flag_n,
    output logic                       regulator_switch_out,
    output logic                       bus_drive_dom
);
    import cfs_pkg::*;

    default clocking @(posedge core_clk); endclocking
    default disable iff (!resetn);

    // ************************************************************
    // Pin synchronisers
    // ************************************************************
    logic [10:0] sync1;
    logic [10:0] sync2;
    logic [10:0] sync3;
    logic [10:0] clean_bits;
    logic [10:0] next_clean;
    cfs_pins_t   pin;
    // A bit moves only once the second and third stages agree, so a
    // single-cycle glitch that escapes the first stage is not taken.
    always_comb begin
        next_clean = (~(sync2 ^ sync3) & sync3) | ((sync2 ^ sync3) & clean_bits);
    end
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            sync1      <= PIN_RST;
            sync2      <= PIN_RST;
            sync3      <= PIN_RST;
            clean_bits <= PIN_RST;
        end else begin
            sync1      <= pins_in;
            sync2      <= sync1;
            sync3      <= sync2;
            clean_bits <= next_clean;
        end
    end
    assign pin = cfs_pins_t'(clean_bits);

    // ************************************************************
    // Mode decode
    // ************************************************************
    cfs_mode_t mode;
    cfs_mode_t next_mode;
    logic      normal;
    logic      lowp;
    // Standby select and enable pins pick the operating mode.
    always_comb begin
        case ({pin.standby_sel_n, pin.mode_en})
            2'b11:   next_mode = MODE_NORMAL;
            2'b10:   next_mode = MODE_VSTBY;
            2'b01:   next_mode = MODE_GOSLEEP;
            2'b00:   next_mode = MODE_LOWP;
            default: next_mode = MODE_LOWP;
        endcase
    end
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            mode <= MODE_LOWP;
        end else begin
            mode <= next_mode;
        end
    end
    assign normal = (mode == MODE_NORMAL);
    assign lowp   = !normal;

    // ************************************************************
    // Control register
    // ************************************************************
    cfs_ctrl_t ctrl;
    cfs_ctrl_t next_ctrl;
    logic      apb_wr;
    logic      apb_setup;
    assign apb_setup = apb_req.psel && !apb_req.penable;
    assign apb_wr    = apb_req.psel && apb_req.penable && apb_req.pwrite;
    assign pready    = 1'b1;
    // Only the three enable bits take a write; the rest stay zero.
    always_comb begin
        next_ctrl = ctrl;
        if (apb_wr && apb_req.paddr == ADDR_CTRL) begin
            next_ctrl      = '0;
            next_ctrl[2:0] = apb_req.pwdata[2:0];
        end
    end
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            ctrl <= cfs_ctrl_t'(CTRL_RST);
        end else begin
            ctrl <= next_ctrl;
        end
    end

    // ************************************************************
    // Wire failure timers (3, 4, 6, 7)
    // ************************************************************
    logic [CW-1:0] det_sel [4];
    logic [CW-1:0] rec_sel [4];
    logic [3:0]    fail_en;
    logic [3:0]    fail;
    // Low power uses one slow pair for 3, 4 and 7; failure 6 is
    // watched only in normal mode.
    always_comb begin
        det_sel[0] = lowp ? LP_DET : CW'(F3_DET_CNT);
        rec_sel[0] = lowp ? LP_REC : CW'(FAST_REC_CNT);
        det_sel[1] = lowp ? LP_DET : F47_DET;
        rec_sel[1] = lowp ? LP_REC : CW'(FAST_REC_CNT);
        det_sel[2] = F6_DET;
        rec_sel[2] = F6_REC;
        det_sel[3] = lowp ? LP_DET : F47_DET;
        rec_sel[3] = lowp ? LP_REC : CW'(FAST_REC_CNT);
        fail_en    = {1'b1, normal, 1'b1, 1'b1};
    end
    for (genvar i = 0; i < 4; i++) begin : g_fail
        cfs_persist_timer u_fail (
            .core_clk (core_clk),
            .resetn   (resetn),
            .en       (fail_en[i]),
            .cond     (pin.fault_cond[i]),
            .det_cnt  (det_sel[i]),
            .rec_cnt  (rec_sel[i]),
            .flag     (fail[i])
        );
    end

    // ************************************************************
    // Edge-count comparison (failures 1, 2, 5)
    // ************************************************************
    logic              canh_q;
    logic              canl_q;
    logic signed [3:0] edge_diff;
    logic signed [3:0] next_diff;
    logic [3:0]        edge_mag;
    logic              fail_125;
    logic              next_f125;
    logic              edge_on;
    assign edge_on  = normal && ctrl.edge_mon_en;
    assign edge_mag = edge_diff[3] ? 4'(-edge_diff) : 4'(edge_diff);
    // An edge on one line without the other moves the difference; it is
    // clamped at the set threshold so recovery needs only two edges.
    always_comb begin
        next_diff = edge_diff;
        next_f125 = fail_125;
        if (!edge_on) begin
            next_diff = '0;
            next_f125 = 1'b0;
        end else begin
            if ((pin.canh_dom != canh_q) && (pin.canl_dom == canl_q) && edge_diff < 4'sd3) begin
                next_diff = edge_diff + 4'sd1;
            end else if ((pin.canl_dom != canl_q) && (pin.canh_dom == canh_q) && edge_diff > -4'sd3) begin
                next_diff = edge_diff - 4'sd1;
            end
            if (edge_mag >= EDGE_SET) begin
                next_f125 = 1'b1;
            end else if (edge_mag <= EDGE_CLR) begin
                next_f125 = 1'b0;
            end
        end
    end
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            canh_q    <= 1'b0;
            canl_q    <= 1'b0;
            edge_diff <= '0;
            fail_125  <= 1'b0;
        end else begin
            canh_q    <= pin.canh_dom;
            canl_q    <= pin.canl_dom;
            edge_diff <= next_diff;
            fail_125  <= next_f125;
        end
    end

    // ************************************************************
    // Wake filters, sleep hold and TXD timeout
    // ************************************************************
    logic bus_wake;
    logic local_wake;
    logic sleep_ok;
    logic tx_timeout;
    cfs_persist_timer u_bus_wake (
        .core_clk (core_clk),
        .resetn   (resetn),
        .en       (lowp && ctrl.bus_wake_en),
        .cond     (pin.canh_dom || pin.canl_dom),
        .det_cnt  (CW'(WAKE_FILT_CNT)),
        .rec_cnt  (CW'(1)),
        .flag     (bus_wake)
    );
    cfs_persist_timer u_local_wake (
        .core_clk (core_clk),
        .resetn   (resetn),
        .en       (lowp && ctrl.local_wake_en),
        .cond     (!pin.wake_n),
        .det_cnt  (CW'(WAKE_FILT_CNT)),
        .rec_cnt  (CW'(1)),
        .flag     (local_wake)
    );
    cfs_persist_timer u_sleep_hold (
        .core_clk (core_clk),
        .resetn   (resetn),
        .en       (1'b1),
        .cond     (mode == MODE_GOSLEEP),
        .det_cnt  (CW'(SLEEP_HOLD_CNT)),
        .rec_cnt  (CW'(1)),
        .flag     (sleep_ok)
    );
    // Recovery count of one cycle rearms the timer as soon as TXD is recessive.
    cfs_persist_timer u_txd_tmo (
        .core_clk (core_clk),
        .resetn   (resetn),
        .en       (1'b1),
        .cond     (!pin.txd),
        .det_cnt  (TXD_TMO),
        .rec_cnt  (CW'(1)),
        .flag     (tx_timeout)
    );

    // ************************************************************
    // Flags and pin outputs
    // ************************************************************
    logic wake_pend;
    logic pwon_flag;
    logic sleep_st;
    logic next_wake;
    logic next_pwon;
    logic next_sleep;
    logic next_err_n;
    logic next_drive;
    // Sets are gated off in normal mode, so a release there always holds;
    // elsewhere a set wins, except that a wake (next_wake) clears sleep even while sleep_ok is set.
    always_comb begin
        next_wake  = (wake_pend && !normal) || ((bus_wake || local_wake) && !normal);
        next_pwon  = (pwon_flag && !normal) || (pin.bat_low && !normal);
        next_sleep = (sleep_st || sleep_ok) && !normal && !next_wake;
        next_drive = normal && !tx_timeout && !pin.txd;
        case (mode)
            MODE_NORMAL:  next_err_n = !(|fail || fail_125);
            MODE_VSTBY:   next_err_n = !pwon_flag;
            MODE_LOWP:    next_err_n = sleep_st || !wake_pend;
            MODE_GOSLEEP: next_err_n = 1'b1;
            default:      next_err_n = 1'b1;
        endcase
    end
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            wake_pend            <= 1'b0;
            pwon_flag            <= 1'b0;
            sleep_st             <= 1'b0;
            fault_flag_n         <= 1'b1;
            bus_drive_dom        <= 1'b0;
            regulator_switch_out <= 1'b1;
        end else begin
            wake_pend            <= next_wake;
            pwon_flag            <= next_pwon;
            sleep_st             <= next_sleep;
            fault_flag_n         <= next_err_n;
            bus_drive_dom        <= next_drive;
            regulator_switch_out <= !next_sleep;
        end
    end

    // ************************************************************
    // APB read path
    // ************************************************************
    cfs_status_t status;
    logic [31:0] next_rdata;
    logic        next_err;
    // Read data is captured in the setup cycle and stands in the access cycle.
    always_comb begin
        status            = '{rsvd: '0, mode: mode, sleep: sleep_st, pwon: pwon_flag, wake: wake_pend,
                              tx_timeout: tx_timeout, fail_125: fail_125, fail: fail};
        next_rdata        = prdata;
        next_err          = pslverr;
        if (apb_setup) begin
            next_err   = 1'b0;
            next_rdata = 32'h0000_0000;
            case (apb_req.paddr)
                ADDR_CTRL:   next_rdata = ctrl;
                ADDR_STATUS: next_rdata = status;
                default:     next_err   = 1'b1;
            endcase
        end
    end
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else begin
            prdata  <= next_rdata;
            pslverr <= next_err;
        end
    end

    // ************************************************************
    // Assertions
    // ************************************************************
    sleep_hold_a: assert property ($rose(sleep_st) |-> $past(sleep_ok) || $past(sleep_st))
        else $error("Sleep entered without the go-to-sleep hold.");
    wake_release_a: assert property (normal |=> !wake_pend)
        else $error("Wake indication survived normal mode.");
    pwon_clear_a: assert property (normal |=> !pwon_flag)
        else $error("Power-on flag survived normal mode.");
    error_flag_a: assert property (normal && (|fail || fail_125) |=> !fault_flag_n)
        else $error("Bus failure not shown on the error flag.");
    edge_set_a: assert property (edge_on && edge_mag >= EDGE_SET ##1 edge_on |-> fail_125)
        else $error("Edge difference of three did not set the failure.");
    edge_clear_a: assert property (edge_on && edge_mag <= EDGE_CLR ##1 edge_on |-> !fail_125)
        else $error("Edge difference of one did not clear the failure.");
    tx_disable_a: assert property (tx_timeout |=> !bus_drive_dom)
        else $error("Transmitter still driving after the timeout.");
    tx_rearm_a: assert property (pin.txd |=> !tx_timeout)
        else $error("Timeout not rearmed by a recessive TXD.");
    wake_gate_a: assert property ($rose(wake_pend) |-> $past(bus_wake || local_wake) && $past(lowp))
        else $error("Wake indication without a filtered wake event.");
    mode_decode_a: assert property (pin.standby_sel_n && !pin.mode_en |=> mode == MODE_VSTBY)
        else $error("Standby code did not select supply standby.");

endmodule // cfs_supervisor
`default_nettype wire
